/* src/clk_pwr_consts.svh */
// constants for the clock, power mode and watchdog controller
`ifndef CLK_PWR_CONSTS_SVH
`define CLK_PWR_CONSTS_SVH

// ***************************************
// register map
// ***************************************
`define CTRL_ADDR 4'h0
`define STAT_ADDR 4'h1
`define CFG_ADDR 4'h2
`define CTRL_RST 16'h0000
`define CTRL_MASK 16'h01ff

// control field positions
`define CTL_SLOW_EN 0
`define CTL_SLOW_SEL 1
`define CTL_FAST_STOP 2
`define CTL_TICK_FAST 3
`define CTL_WAKE_IE 4
`define CTL_SLOW_SRC_LO 5
`define CTL_SLOW_SRC_HI 6
`define CTL_WDT_PER_LO 7
`define CTL_WDT_PER_HI 8

// status field positions
`define STA_MODE_LO 0
`define STA_MODE_HI 3
`define STA_EXPIRY 4
`define STA_PDOWN 5
`define STA_ON_SLOW 6
`define STA_SWITCHING 7

// config word fields
`define CFG_FAST_SRC_LO 8
`define CFG_FAST_SRC_HI 9
`define CFG_DOG_RST_EN 6

// fast source codes
`define FSRC_XTAL 2'h3
`define FSRC_PLL 2'h2
`define FSRC_IRC 2'h1
`define FSRC_ERC 2'h0

// ***************************************
// watchdog timing
// ***************************************
`define WDT_RC_TICK_US 500
`define WDT_P0_US 3500
`define WDT_P1_US 7000
`define WDT_P2_US 28000
`define WDT_P3_US 112000
`define WDT_CNT_W 8

`endif

/* src/clk_pwr_pkg.sv */
// types for the clock, power mode and watchdog controller
package clk_pwr_pkg;

  // operating modes, one-hot
  typedef enum logic [3:0] {
    MODE_FAST = 4'b0001,
    MODE_SLOW = 4'b0010,
    MODE_IDLE = 4'b0100,
    MODE_STOP = 4'b1000
  } mode_t;

  // controller state
  typedef struct packed {
    mode_t mode;
    logic [15:0] ctrl;
    logic expiry;
    logic pdown;
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    logic [1:0] f;
    logic cur_slow;
    logic gate_on;
    logic cpu_clk;
    logic [15:0] rdata;
    logic dog_rst;
  } ctl_state_t;

  // watchdog counter state
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic f;
    logic [7:0] cnt;
    logic ovf;
  } wdt_state_t;

endpackage

/* src/wdt_counter.sv */
// shared watchdog and wake-up counter on the rc oscillator pin
`timescale 1ns/10ps
`include "clk_pwr_consts.svh"

module wdt_counter
  import clk_pwr_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // rc oscillator pin
  input wire logic rc_i,
  // control
  input wire logic run_i,
  input wire logic clear_i,
  input wire logic [1:0] period_sel_i,
  // overflow pulse
  output logic ovf_o
);

  wdt_state_t q, d;
  logic agree;
  logic tick;
  logic [7:0] limit;

  // overflow limit in rc ticks, rounded down
  always_comb begin
    unique case (period_sel_i)
      2'h0: limit = 8'(`WDT_P0_US / `WDT_RC_TICK_US);
      2'h1: limit = 8'(`WDT_P1_US / `WDT_RC_TICK_US);
      2'h2: limit = 8'(`WDT_P2_US / `WDT_RC_TICK_US);
      2'h3: limit = 8'(`WDT_P3_US / `WDT_RC_TICK_US);
    endcase
  end

  // sync, filter, count
  always_comb begin
    d = q;
    d.ovf = 1'b0;
    d.s1 = rc_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
    agree = (q.s2 == q.s3);
    tick = agree & q.s3 & ~q.f;
    if (agree) begin
      d.f = q.s3;
    end
    if (clear_i || !run_i) begin
      d.cnt = '0;
    end else if (tick) begin
      if (q.cnt == limit - 8'h01) begin
        d.cnt = '0;
        d.ovf = 1'b1;
      end else begin
        d.cnt = q.cnt + 8'h01;
      end
    end
  end

  // state register
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign ovf_o = q.ovf;

  // checks
  clear_restart_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    clear_i |=> (q.cnt == 8'h00) && !ovf_o)
    else $error("counter not restarted by clear");

  halt_counter_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    !run_i [*2] |-> q.cnt == 8'h00 && !ovf_o)
    else $error("halted counter still counting");

  ovf_wrap_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    ovf_o |-> q.cnt == 8'h00 && $past(q.cnt) == $past(limit) - 8'h01)
    else $error("overflow at wrong count");

endmodule // wdt_counter

/* src/clk_pwr_ctrl.sv */
// dual clock selection, power modes and watchdog control
`timescale 1ns/10ps
`include "clk_pwr_consts.svh"

module clk_pwr_ctrl
  import clk_pwr_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // register port
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  // non-volatile configuration
  input wire logic [13:0] config_word_i,
  // instructions
  input wire logic sleep_i,
  input wire logic clear_dog_instruction_i,
  // wake sources
  input wire logic external_pin_interrupt_i,
  input wire logic port_a_wake_i,
  input wire logic port_b_wake_i,
  input wire logic rfc_int_i,
  input wire logic tick_int_i,
  // oscillator pins
  input wire logic fast_osc_i,
  input wire logic slow_osc_i,
  input wire logic wdt_rc_i,
  // oscillator control
  output logic fast_osc_en_o,
  output logic slow_osc_en_o,
  output logic wdt_rc_en_o,
  output logic [3:0] fast_src_o,
  output logic [3:0] slow_src_o,
  // clocks and run gates
  output logic cpu_clk_o,
  output logic cpu_run_o,
  output logic periph_run_o,
  output logic periph_on_slow_o,
  output logic tick_on_fast_o,
  output logic tick_run_o,
  // mode and watchdog events
  output logic [3:0] mode_o,
  output logic chip_reset_o,
  output logic wakeup_timer_irq_o
);

  ctl_state_t q, d;

  // ***************************************
  // decoded controls
  // ***************************************
  logic slow_en;
  logic slow_sel;
  logic fast_stop;
  logic wake_ie;
  logic watchdog_reset_enable;
  logic sleeping;
  logic wdt_run;
  logic wdt_clear;
  logic wdt_ovf;
  logic wakeup_timer_wake;
  logic idle_wake;
  logic stop_wake;
  logic lvl_cur;
  logic lvl_new;
  logic [1:0] agree;
  logic [15:0] status;

  // control bits and configuration
  assign slow_en = q.ctrl[`CTL_SLOW_EN];
  assign slow_sel = q.ctrl[`CTL_SLOW_SEL];
  assign fast_stop = q.ctrl[`CTL_FAST_STOP];
  assign wake_ie = q.ctrl[`CTL_WAKE_IE];
  assign watchdog_reset_enable = config_word_i[`CFG_DOG_RST_EN];
  assign sleeping = (q.mode == MODE_IDLE) || (q.mode == MODE_STOP);

  // ***************************************
  // watchdog and wake timer
  // ***************************************

  // rc runs per both enables awake, per wake enable only asleep
  always_comb begin
    if (sleeping) begin
      wdt_run = wake_ie;
    end else begin
      wdt_run = watchdog_reset_enable | wake_ie;
    end
  end

  // restart on clear-dog or watchdog reset
  assign wdt_clear = clear_dog_instruction_i | q.dog_rst;

  wdt_counter u_wdt (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .rc_i(wdt_rc_i),
    .run_i(wdt_run),
    .clear_i(wdt_clear),
    .period_sel_i(q.ctrl[`CTL_WDT_PER_HI:`CTL_WDT_PER_LO]),
    .ovf_o(wdt_ovf)
  );

  // overflow becomes reset or wake interrupt
  assign wakeup_timer_irq_o = wdt_ovf & ~watchdog_reset_enable;
  assign wakeup_timer_wake = wakeup_timer_irq_o & wake_ie;
  assign wdt_rc_en_o = wdt_run;

  // wake qualifiers per sleep mode
  assign stop_wake = external_pin_interrupt_i | port_a_wake_i |
                     port_b_wake_i | wakeup_timer_wake;
  assign idle_wake = stop_wake | rfc_int_i | tick_int_i;

  // ***************************************
  // clock source switch levels
  // ***************************************
  assign lvl_cur = q.cur_slow ? q.f[1] : q.f[0];
  assign lvl_new = slow_sel ? q.f[1] : q.f[0];
  assign agree = ~(q.s2 ^ q.s3);

  // ***************************************
  // status word
  // ***************************************
  always_comb begin
    status = 16'h0000;
    status[`STA_MODE_HI:`STA_MODE_LO] = q.mode;
    status[`STA_EXPIRY] = q.expiry;
    status[`STA_PDOWN] = q.pdown;
    status[`STA_ON_SLOW] = q.cur_slow;
    // a gate closed for sleep is not a pending switch
    status[`STA_SWITCHING] = (q.cur_slow != slow_sel) |
                             (~q.gate_on & ~sleeping);
  end

  // ***************************************
  // next state
  // ***************************************
  always_comb begin
    d = q;
    d.dog_rst = 1'b0;

    // oscillator pin sync, change taken when stages agree
    d.s1 = {slow_osc_i, fast_osc_i};
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.f = (agree & q.s3) | (~agree & q.f);

    // register writes
    if (wr_i && addr_i == `CTRL_ADDR) begin
      d.ctrl = wdata_i & `CTRL_MASK;
    end

    // register reads, data for one cycle only
    d.rdata = 16'h0000;
    if (rd_i) begin
      unique case (addr_i)
        `CTRL_ADDR: d.rdata = q.ctrl;
        `STAT_ADDR: d.rdata = status;
        `CFG_ADDR: d.rdata = {2'h0, config_word_i};
        default: d.rdata = 16'h0000;
      endcase
    end

    // mode sequencing
    unique case (q.mode)
      MODE_FAST, MODE_SLOW: begin
        if (sleep_i) begin
          d.pdown = 1'b1;
          d.mode = slow_en ? MODE_IDLE : MODE_STOP;
        end else begin
          d.mode = d.ctrl[`CTL_SLOW_SEL] ? MODE_SLOW : MODE_FAST;
        end
      end
      MODE_IDLE: begin
        if (idle_wake) begin
          d.mode = slow_sel ? MODE_SLOW : MODE_FAST;
        end
      end
      MODE_STOP: begin
        if (stop_wake) begin
          d.mode = slow_sel ? MODE_SLOW : MODE_FAST;
        end
      end
    endcase

    // expiry flag, set beats clear
    if (sleep_i || clear_dog_instruction_i) begin
      d.expiry = 1'b0;
    end
    if (clear_dog_instruction_i && !(sleep_i && !sleeping)) begin
      d.pdown = 1'b0; // sleep set wins
    end
    if (wdt_ovf && watchdog_reset_enable) begin
      d.expiry = 1'b1;
      d.dog_rst = 1'b1;
    end

    // glitch-free source switch, gates only change on a low level
    if (q.gate_on) begin
      if ((q.cur_slow != slow_sel || sleeping) && !lvl_cur) begin
        d.gate_on = 1'b0;
      end
    end else if (!sleeping && !lvl_new) begin
      d.cur_slow = slow_sel;
      d.gate_on = 1'b1;
    end
    d.cpu_clk = q.gate_on & lvl_cur;

    // watchdog reset restores controls, flags survive
    if (q.dog_rst) begin
      d.ctrl = `CTRL_RST;
      d.mode = MODE_FAST;
    end
  end

  // ***************************************
  // state register
  // ***************************************
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      q <= '0;
      q.mode <= MODE_FAST;
      q.ctrl <= `CTRL_RST;
      q.gate_on <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ***************************************
  // outputs
  // ***************************************

  // register port and mode
  assign rdata_o = q.rdata;
  assign mode_o = q.mode;
  assign chip_reset_o = q.dog_rst;
  assign cpu_clk_o = q.cpu_clk;

  // fast source from config word, one-hot
  always_comb begin
    fast_src_o = 4'h0;
    unique case (config_word_i[`CFG_FAST_SRC_HI:`CFG_FAST_SRC_LO])
      `FSRC_XTAL: fast_src_o = 4'h8;
      `FSRC_PLL: fast_src_o = 4'h4;
      `FSRC_IRC: fast_src_o = 4'h2;
      `FSRC_ERC: fast_src_o = 4'h1;
    endcase
  end

  // slow source from control field, one-hot
  always_comb begin
    slow_src_o = 4'h0;
    slow_src_o[q.ctrl[`CTL_SLOW_SRC_HI:`CTL_SLOW_SRC_LO]] = 1'b1;
  end

  // oscillator enables
  assign fast_osc_en_o = ~sleeping &
                         ((q.mode == MODE_FAST) | ~fast_stop);
  assign slow_osc_en_o = (~sleeping & (slow_en | slow_sel)) |
                         (q.mode == MODE_IDLE);

  // run gates per mode
  assign cpu_run_o = ~sleeping;
  assign periph_run_o = ~sleeping;
  assign periph_on_slow_o = (q.mode == MODE_SLOW);
  assign tick_on_fast_o = (q.mode == MODE_FAST) &
                          q.ctrl[`CTL_TICK_FAST];
  assign tick_run_o = (q.mode != MODE_STOP) &
                      ((q.mode != MODE_IDLE) | slow_en);

  // ***************************************
  // checks
  // ***************************************
  fast_after_reset_a: assert property (
    @(posedge sys_clk_i)
    $past(reset_i) && !reset_i |-> mode_o == MODE_FAST)
    else $error("not in fast mode after reset");

  idle_entry_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    sleep_i && !sleeping && slow_en && !q.dog_rst
    |=> mode_o == MODE_IDLE && !cpu_run_o)
    else $error("sleep with slow clock did not enter idle");

  stop_entry_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    sleep_i && !sleeping && !slow_en && !q.dog_rst
    |=> mode_o == MODE_STOP && !slow_osc_en_o && !fast_osc_en_o)
    else $error("sleep without slow clock did not stop");

  slow_keep_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    !sleeping && slow_sel |-> slow_osc_en_o)
    else $error("slow oscillator off while selected");

  stop_hold_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    mode_o == MODE_STOP && !stop_wake && !q.dog_rst
    |=> mode_o == MODE_STOP)
    else $error("stop mode left without a wake source");

  idle_wake_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    mode_o == MODE_IDLE && tick_int_i |=> !sleeping)
    else $error("tick interrupt did not wake idle");

  dog_reset_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    wdt_ovf && watchdog_reset_enable |=> chip_reset_o && q.expiry ##1
    mode_o == MODE_FAST && q.ctrl == `CTRL_RST)
    else $error("watchdog overflow did not reset controls");

  flag_keep_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    chip_reset_o && q.pdown && !clear_dog_instruction_i |=> q.pdown)
    else $error("power-down flag lost on watchdog reset");

  rc_stop_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    !sleeping && !watchdog_reset_enable && !wake_ie |-> !wdt_rc_en_o)
    else $error("rc oscillator running with both enables off");

  clk_glitch_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    $fell(q.gate_on) |-> !cpu_clk_o && !$past(lvl_cur))
    else $error("clock gate closed on a high level");

endmodule // clk_pwr_ctrl

/* sim/tb.sv */
// self-checking bench for the clock, power mode and watchdog controller
`timescale 1ns/10ps
`include "clk_pwr_consts.svh"
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin \
  num_errors++; $display("unexpected %s exp %h got %h", nm, exp, got); \
  end end

module tb
  import clk_pwr_pkg::*;
;
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [13:0] config_word_i = 14'h0000;
  logic sleep_i = 1'b0;
  logic clr_i = 1'b0;
  logic [4:0] wake = 5'h00;
  logic [7:0] div_q = 8'h00;
  logic rc = 1'b0;
  logic [15:0] rdata_o, d;
  logic [3:0] fast_src_o, slow_src_o, mode_o;
  logic fast_osc_en_o, slow_osc_en_o, wdt_rc_en_o, cpu_clk_o, cpu_run_o;
  logic periph_run_o, periph_on_slow_o, tick_on_fast_o, tick_run_o;
  logic chip_reset_o, wakeup_timer_irq_o;
  int num_errors = 0;
  int compares = 0;
  int n_rst = 0;
  int n_irq = 0;
  int hi_run = 0;

  // clock and oscillator pins
  always #50 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) div_q <= div_q + 8'h01;

  // event counters and clock pulse width monitor
  always @(posedge sys_clk_i) begin
    if (chip_reset_o === 1'b1) n_rst++;
    if (wakeup_timer_irq_o === 1'b1) n_irq++;
    if (cpu_clk_o === 1'b1) hi_run++;
    else begin
      if (hi_run != 0) `CHK("clock high run", 1'b1, hi_run >= 3)
      hi_run = 0;
    end
  end

  clk_pwr_ctrl i_dut (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .config_word_i(config_word_i), .sleep_i(sleep_i),
    .clear_dog_instruction_i(clr_i), .external_pin_interrupt_i(wake[0]),
    .port_a_wake_i(wake[1]), .port_b_wake_i(wake[2]), .rfc_int_i(wake[3]),
    .tick_int_i(wake[4]), .fast_osc_i(div_q[2]), .slow_osc_i(div_q[5]),
    .wdt_rc_i(rc), .fast_osc_en_o(fast_osc_en_o),
    .slow_osc_en_o(slow_osc_en_o), .wdt_rc_en_o(wdt_rc_en_o),
    .fast_src_o(fast_src_o), .slow_src_o(slow_src_o), .cpu_clk_o(cpu_clk_o),
    .cpu_run_o(cpu_run_o), .periph_run_o(periph_run_o),
    .periph_on_slow_o(periph_on_slow_o), .tick_on_fast_o(tick_on_fast_o),
    .tick_run_o(tick_run_o), .mode_o(mode_o), .chip_reset_o(chip_reset_o),
    .wakeup_timer_irq_o(wakeup_timer_irq_o)
  );

  // ****************************************
  // bus and pulse tasks
  // ****************************************
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge sys_clk_i) begin
      wr_i <= 1'b1; addr_i <= a; wdata_i <= v;
    end
    @(posedge sys_clk_i) wr_i <= 1'b0;
    @(negedge sys_clk_i);
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk_i) begin
      rd_i <= 1'b1; addr_i <= a;
    end
    @(posedge sys_clk_i) rd_i <= 1'b0;
    @(negedge sys_clk_i) d = rdata_o;
  endtask

  task automatic slp();
    @(posedge sys_clk_i) sleep_i <= 1'b1;
    @(posedge sys_clk_i) sleep_i <= 1'b0;
    @(negedge sys_clk_i);
  endtask

  task automatic clr_dog();
    @(posedge sys_clk_i) clr_i <= 1'b1;
    @(posedge sys_clk_i) clr_i <= 1'b0;
    @(negedge sys_clk_i);
  endtask

  task automatic wk(input int i);
    @(posedge sys_clk_i) wake[i] <= 1'b1;
    @(posedge sys_clk_i) wake[i] <= 1'b0;
    @(negedge sys_clk_i);
  endtask

  // rc oscillator rising edges, slow enough for the synchroniser
  task automatic rc_ticks(input int n);
    repeat (n) begin
      @(posedge sys_clk_i) rc <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      rc <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
    end
    @(negedge sys_clk_i);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic test_reset();
    `CHK("mode", MODE_FAST, mode_o)
    rd(`CTRL_ADDR); `CHK("ctrl", `CTRL_RST, d)
    wr(`CTRL_ADDR, 16'hffff);
    rd(`CTRL_ADDR); `CHK("ctrl mask", `CTRL_MASK, d)
    wr(`CTRL_ADDR, 16'h0000);
    wr(`STAT_ADDR, 16'hffff);
    repeat (60) @(negedge sys_clk_i);
    rd(`STAT_ADDR); `CHK("status", 16'h0001, d)
    rd(4'hf); `CHK("unmapped", 16'h0000, d)
    rd(`CFG_ADDR); `CHK("config", {2'b00, config_word_i}, d)
    $display("reset test done");
  endtask

  task automatic test_fast();
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk_i) config_word_i <= 14'(i << 8);
      @(negedge sys_clk_i);
      `CHK("fast source", 4'(1 << i), fast_src_o)
    end
    config_word_i <= 14'h0000;
    wr(`CTRL_ADDR, 16'h0008);
    `CHK("tick on fast", 1'b1, tick_on_fast_o)
    `CHK("periph on slow", 1'b0, periph_on_slow_o)
    wr(`CTRL_ADDR, 16'h0001);
    `CHK("slow osc on", 1'b1, slow_osc_en_o)
    wr(`CTRL_ADDR, 16'h0000);
    `CHK("slow osc off", 1'b0, slow_osc_en_o)
    $display("fast test done");
  endtask

  task automatic test_slow();
    wr(`CTRL_ADDR, 16'h0002);
    `CHK("slow osc kept", 1'b1, slow_osc_en_o)
    wr(`CTRL_ADDR, 16'h0001);
    wr(`CTRL_ADDR, 16'h0003);
    wr(`CTRL_ADDR, 16'h0007);
    repeat (60) @(negedge sys_clk_i);
    `CHK("mode slow", MODE_SLOW, mode_o)
    `CHK("fast osc", 1'b0, fast_osc_en_o)
    `CHK("periph slow", 1'b1, periph_on_slow_o)
    for (int i = 0; i < 4; i++) begin
      wr(`CTRL_ADDR, 16'h0007 | 16'(i << 5));
      `CHK("slow source", 4'(1 << i), slow_src_o)
    end
    slp();
    `CHK("mode idle", MODE_IDLE, mode_o)
    `CHK("tick run", 1'b1, tick_run_o)
    `CHK("periph run", 1'b0, periph_run_o)
    wk(4);
    `CHK("wake to slow", MODE_SLOW, mode_o)
    wr(`CTRL_ADDR, 16'h0003);
    wr(`CTRL_ADDR, 16'h0001);
    wr(`CTRL_ADDR, 16'h0000);
    repeat (60) @(negedge sys_clk_i);
    `CHK("mode fast", MODE_FAST, mode_o)
    `CHK("fast osc", 1'b1, fast_osc_en_o)
    $display("slow test done");
  endtask

  task automatic test_sleep();
    logic woke;
    for (int s = 0; s < 2; s++) begin
      for (int i = 0; i < 5; i++) begin
        wr(`CTRL_ADDR, 16'(s));
        slp();
        `CHK("asleep", s ? MODE_IDLE : MODE_STOP, mode_o)
        `CHK("cpu run", 1'b0, cpu_run_o)
        `CHK("slow osc", s[0], slow_osc_en_o)
        `CHK("tick run", s[0], tick_run_o)
        wk(i);
        woke = (s == 1) || (i < 3);
        `CHK("woken", woke ? MODE_FAST : MODE_STOP, mode_o)
        if (!woke) wk(0);
      end
    end
    $display("sleep test done");
  endtask

  task automatic test_dog();
    @(posedge sys_clk_i) config_word_i <= 14'h0040;
    wr(`CTRL_ADDR, 16'h0008);
    `CHK("rc enable", 1'b1, wdt_rc_en_o)
    clr_dog();
    n_rst = 0;
    rc_ticks(5);
    clr_dog();
    rc_ticks(6);
    `CHK("no reset", 0, n_rst)
    rc_ticks(1);
    `CHK("dog reset", 1, n_rst)
    `CHK("no irq", 0, n_irq)
    rd(`CTRL_ADDR); `CHK("ctrl back", 16'h0000, d)
    rd(`STAT_ADDR); `CHK("expiry", 16'h0011, d)
    slp();
    `CHK("rc stopped", 1'b0, wdt_rc_en_o)
    rd(`STAT_ADDR); `CHK("sleep flags", 16'h0028, d)
    rc_ticks(10);
    `CHK("halted", 1, n_rst)
    wk(0);
    rc_ticks(7);
    `CHK("dog reset", 2, n_rst)
    rd(`STAT_ADDR); `CHK("flags kept", 16'h0031, d)
    clr_dog();
    rd(`STAT_ADDR); `CHK("flags clear", 16'h0001, d)
    $display("watchdog test done");
  endtask

  task automatic test_wake_timer();
    @(posedge sys_clk_i) config_word_i <= 14'h0000;
    wr(`CTRL_ADDR, 16'h0000);
    `CHK("rc off", 1'b0, wdt_rc_en_o)
    wr(`CTRL_ADDR, 16'h0090);
    `CHK("rc on", 1'b1, wdt_rc_en_o)
    clr_dog();
    slp();
    n_irq = 0;
    rc_ticks(13);
    `CHK("no irq", 0, n_irq)
    `CHK("still stop", MODE_STOP, mode_o)
    rc_ticks(1);
    `CHK("wake irq", 1, n_irq)
    `CHK("no reset", 2, n_rst)
    `CHK("timer wake", MODE_FAST, mode_o)
    $display("wake timer test done");
  endtask

  // ****************************************
  // run control
  // ****************************************
  task automatic test_done();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (3) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    @(negedge sys_clk_i);
    test_reset();
    test_fast();
    test_slow();
    test_sleep();
    test_dog();
    test_wake_timer();
    test_done();
  end

  // hang guard, well beyond the expected run
  initial begin
    #4000000;
    num_errors++;
    $display("watchdog expired");
    test_done();
  end
endmodule // tb
